// file: verilog/ext_memory_bus_control.sv
// external program/data memory bus sequencer with reset, idle and power-down
// Behaviour
// - address latch strobe pulses at one sixth of oscillator rate in normal running.
// - an external data access skips exactly one address latch strobe pulse.
// - each address latch strobe of an external access marks the low address byte on port 0.
// - port 0 carries low address then data during external accesses.
// - port 2 carries the high address byte during external accesses.
// - external program fetch strobe asserts twice per machine cycle.
// - an external data cycle skips both program fetch strobe activations.
// - internal program fetches never assert the program fetch strobe.
// - fetch select high: internal fetch unless program counter exceeds 0FFFH.
// - fetch select low: every fetch goes to external program memory.
// - reset pin high for two machine cycles resets; the driver holds it.
// - idle halts the CPU; RAM, timers, serial and interrupts keep running.
// - power-down stops the oscillator, keeping RAM; only reset leaves it.
// - external data write strobe is the alternate function of port 3 bit 6.
// - in programming mode the latch strobe pin becomes the program pulse input.
`timescale 1ns/1ns
`default_nettype none
module ext_memory_bus_control (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic RESET_PIN_I,
  input wire logic INTERNAL_FETCH_SELECT_I,
  input wire logic PROGRAM_PULSE_MODE_I,
  input wire logic ADDRESS_LATCH_STROBE_I,
  input wire logic [15:0] CODE_ADDR_I,
  input wire logic XDATA_REQ_I,
  input wire logic XDATA_WE_I,
  input wire logic [15:0] XDATA_ADDR_I,
  input wire logic [7:0] XDATA_WDATA_I,
  input wire logic IDLE_REQ_I,
  input wire logic PDOWN_REQ_I,
  input wire logic WAKE_I,
  input wire logic [7:0] P0_I,
  output logic CORE_RESET_O,
  output logic ADDRESS_LATCH_STROBE_O,
  output logic ADDRESS_LATCH_STROBE_OE_O,
  output logic PROGRAM_PULSE_O,
  output logic PROGRAM_FETCH_STROBE_N_O,
  output logic PROGRAM_FETCH_STROBE_OE_O,
  output logic [7:0] P0_O,
  output logic P0_OE_O,
  output logic [7:0] P2_O,
  output logic P2_OE_O,
  output logic DATA_WRITE_STROBE_N_O,
  output logic DATA_READ_STROBE_N_O,
  output logic [7:0] CODE_DATA_O,
  output logic CODE_VALID_O,
  output logic [7:0] XDATA_RDATA_O,
  output logic XDATA_DONE_O,
  output logic XDATA_BUSY_O,
  output logic CPU_HALT_O,
  output logic OSC_STOP_O
);
  logic core_rst, clr, boundary, slot_end, take;
  logic [3:0] sp;
  ext_bus_pkg::mode_e mode_r, mode_nxt;
  logic [3:0] phase_r, phase_nxt;
  logic dcyc_r, dcyc_nxt, dpend_r, dpend_nxt, dwe_r, dwe_nxt;
  logic [15:0] daddr_r, daddr_nxt;
  logic [7:0] dwdata_r, dwdata_nxt;
  logic slot_ext_r, slot_ext_nxt;
  logic [15:0] caddr_r, caddr_nxt;
  logic busy_r, busy_nxt, halt_r, halt_nxt, stop_r, stop_nxt;
  logic als_r, als_nxt, als_oe_r, als_oe_nxt;
  logic program_pulse_r, program_pulse_nxt;
  logic pfs_n_r, pfs_n_nxt, pfs_oe_r, pfs_oe_nxt;
  logic [7:0] p0_r, p0_nxt;
  logic p0_oe_r, p0_oe_nxt;
  logic [7:0] p2_r, p2_nxt;
  logic p2_oe_r, p2_oe_nxt;
  logic wr_n_r, wr_n_nxt, rd_n_r, rd_n_nxt;
  logic [7:0] cdata_r, cdata_nxt;
  logic cvalid_r, cvalid_nxt;
  logic [7:0] xrdata_r, xrdata_nxt;
  logic xdone_r, xdone_nxt;

  bus_reset_qualify #(
    .HOLD(ext_bus_pkg::RST_HOLD_CYC)
  ) u_rst_qual (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(RESET_PIN_I),
    .qual_o(core_rst)
  );

  assign clr = !RST_N_I || core_rst;
  assign boundary = (phase_r == ext_bus_pkg::PH_LAST);
  assign slot_end = boundary || (phase_r == ext_bus_pkg::SLOT_LAST);
  assign sp = (phase_r >= ext_bus_pkg::SLOT_LEN) ? phase_r - ext_bus_pkg::SLOT_LEN : phase_r;
  assign take = XDATA_REQ_I && !busy_r && (mode_r == ext_bus_pkg::MODE_RUN) && !PROGRAM_PULSE_MODE_I;

  // sequencer: machine-cycle phase, power modes, data-cycle scheduling
  always_comb begin
    phase_nxt = boundary ? 4'h0 : phase_r + 4'h1;
    mode_nxt = mode_r;
    dcyc_nxt = dcyc_r;
    dpend_nxt = dpend_r;
    dwe_nxt = dwe_r;
    daddr_nxt = daddr_r;
    dwdata_nxt = dwdata_r;
    slot_ext_nxt = slot_ext_r;
    caddr_nxt = caddr_r;
    if (take) begin
      dpend_nxt = 1'b1;
      dwe_nxt = XDATA_WE_I;
      daddr_nxt = XDATA_ADDR_I;
      dwdata_nxt = XDATA_WDATA_I;
    end
    if (slot_end) begin
      slot_ext_nxt = !INTERNAL_FETCH_SELECT_I || (CODE_ADDR_I > ext_bus_pkg::INT_CODE_TOP);
      caddr_nxt = CODE_ADDR_I;
    end
    if (boundary) begin
      dcyc_nxt = 1'b0;
      case (mode_r)
        ext_bus_pkg::MODE_RUN: begin
          // a pending data access runs before the core may sleep
          if (dpend_r) begin
            dcyc_nxt = 1'b1;
            dpend_nxt = 1'b0;
          end else if (PDOWN_REQ_I) begin
            mode_nxt = ext_bus_pkg::MODE_PDOWN;
          end else if (IDLE_REQ_I) begin
            mode_nxt = ext_bus_pkg::MODE_IDLE;
          end
        end
        ext_bus_pkg::MODE_IDLE: begin
          if (WAKE_I) begin
            mode_nxt = ext_bus_pkg::MODE_RUN;
          end
        end
        ext_bus_pkg::MODE_PDOWN: begin
          mode_nxt = ext_bus_pkg::MODE_PDOWN;
        end
        default: begin
          mode_nxt = ext_bus_pkg::MODE_RUN;
        end
      endcase
    end
    if (mode_r == ext_bus_pkg::MODE_PDOWN) begin
      phase_nxt = 4'h0;
    end
    busy_nxt = dpend_nxt || dcyc_nxt;
    halt_nxt = (mode_nxt == ext_bus_pkg::MODE_IDLE);
    stop_nxt = (mode_nxt == ext_bus_pkg::MODE_PDOWN);
  end

  // pin drivers and returned data
  always_comb begin
    als_nxt = 1'b0;
    als_oe_nxt = 1'b1;
    program_pulse_nxt = 1'b0;
    pfs_n_nxt = 1'b1;
    pfs_oe_nxt = 1'b1;
    p0_nxt = ext_bus_pkg::BUS_RST;
    p0_oe_nxt = 1'b0;
    p2_nxt = p2_r;
    p2_oe_nxt = 1'b0;
    wr_n_nxt = 1'b1;
    rd_n_nxt = 1'b1;
    cdata_nxt = cdata_r;
    cvalid_nxt = 1'b0;
    xrdata_nxt = xrdata_r;
    xdone_nxt = 1'b0;
    if (PROGRAM_PULSE_MODE_I) begin
      // programmer owns the strobe pins; the latch pin is an input here
      als_oe_nxt = 1'b0;
      pfs_oe_nxt = 1'b0;
      program_pulse_nxt = !ADDRESS_LATCH_STROBE_I;
    end else if (mode_r == ext_bus_pkg::MODE_RUN) begin
      if (dcyc_r) begin
        als_nxt = (phase_r <= ext_bus_pkg::SP_ALS_LAST);
        p2_nxt = daddr_r[15:8];
        p2_oe_nxt = 1'b1;
        if (phase_r <= ext_bus_pkg::SP_ADDR_LAST) begin
          p0_nxt = daddr_r[7:0];
          p0_oe_nxt = 1'b1;
        end else if (dwe_r && phase_r <= ext_bus_pkg::DC_SAMPLE) begin
          p0_nxt = dwdata_r;
          p0_oe_nxt = 1'b1;
        end
        if (phase_r >= ext_bus_pkg::DC_STB_FIRST && phase_r <= ext_bus_pkg::DC_STB_LAST) begin
          wr_n_nxt = !dwe_r;
          rd_n_nxt = dwe_r;
        end
        if (phase_r == ext_bus_pkg::DC_SAMPLE) begin
          xdone_nxt = 1'b1;
          if (!dwe_r) begin
            xrdata_nxt = P0_I;
          end
        end
      end else begin
        // latch strobe keeps its rate even for internal fetches
        als_nxt = (sp <= ext_bus_pkg::SP_ALS_LAST);
        if (slot_ext_r) begin
          p2_nxt = caddr_r[15:8];
          p2_oe_nxt = 1'b1;
          if (sp <= ext_bus_pkg::SP_ADDR_LAST) begin
            p0_nxt = caddr_r[7:0];
            p0_oe_nxt = 1'b1;
          end
          if (sp >= ext_bus_pkg::SP_STB_FIRST && sp <= ext_bus_pkg::SP_STB_LAST) begin
            pfs_n_nxt = 1'b0;
          end
          if (sp == ext_bus_pkg::SP_SAMPLE) begin
            cdata_nxt = P0_I;
            cvalid_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (clr) begin
      phase_r <= 4'h0;
      mode_r <= ext_bus_pkg::MODE_RUN;
      dcyc_r <= 1'b0;
      dpend_r <= 1'b0;
      dwe_r <= 1'b0;
      daddr_r <= ext_bus_pkg::ADDR_RST;
      dwdata_r <= ext_bus_pkg::BUS_RST;
      slot_ext_r <= 1'b0;
      caddr_r <= ext_bus_pkg::ADDR_RST;
      busy_r <= 1'b0;
      halt_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      mode_r <= mode_nxt;
      dcyc_r <= dcyc_nxt;
      dpend_r <= dpend_nxt;
      dwe_r <= dwe_nxt;
      daddr_r <= daddr_nxt;
      dwdata_r <= dwdata_nxt;
      slot_ext_r <= slot_ext_nxt;
      caddr_r <= caddr_nxt;
      busy_r <= busy_nxt;
      halt_r <= halt_nxt;
      stop_r <= stop_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (clr) begin
      als_r <= 1'b0;
      als_oe_r <= 1'b1;
      program_pulse_r <= 1'b0;
      pfs_n_r <= 1'b1;
      pfs_oe_r <= 1'b1;
      p0_r <= ext_bus_pkg::BUS_RST;
      p0_oe_r <= 1'b0;
      p2_r <= ext_bus_pkg::BUS_RST;
      p2_oe_r <= 1'b0;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      cdata_r <= ext_bus_pkg::BUS_RST;
      cvalid_r <= 1'b0;
      xrdata_r <= ext_bus_pkg::BUS_RST;
      xdone_r <= 1'b0;
    end else begin
      als_r <= als_nxt;
      als_oe_r <= als_oe_nxt;
      program_pulse_r <= program_pulse_nxt;
      pfs_n_r <= pfs_n_nxt;
      pfs_oe_r <= pfs_oe_nxt;
      p0_r <= p0_nxt;
      p0_oe_r <= p0_oe_nxt;
      p2_r <= p2_nxt;
      p2_oe_r <= p2_oe_nxt;
      wr_n_r <= wr_n_nxt;
      rd_n_r <= rd_n_nxt;
      cdata_r <= cdata_nxt;
      cvalid_r <= cvalid_nxt;
      xrdata_r <= xrdata_nxt;
      xdone_r <= xdone_nxt;
    end
  end

  assign CORE_RESET_O = core_rst;
  assign ADDRESS_LATCH_STROBE_O = als_r;
  assign ADDRESS_LATCH_STROBE_OE_O = als_oe_r;
  assign PROGRAM_PULSE_O = program_pulse_r;
  assign PROGRAM_FETCH_STROBE_N_O = pfs_n_r;
  assign PROGRAM_FETCH_STROBE_OE_O = pfs_oe_r;
  assign P0_O = p0_r;
  assign P0_OE_O = p0_oe_r;
  assign P2_O = p2_r;
  assign P2_OE_O = p2_oe_r;
  assign DATA_WRITE_STROBE_N_O = wr_n_r;
  assign DATA_READ_STROBE_N_O = rd_n_r;
  assign CODE_DATA_O = cdata_r;
  assign CODE_VALID_O = cvalid_r;
  assign XDATA_RDATA_O = xrdata_r;
  assign XDATA_DONE_O = xdone_r;
  assign XDATA_BUSY_O = busy_r;
  assign CPU_HALT_O = halt_r;
  assign OSC_STOP_O = stop_r;
  // helper: length of the current high run on the reset pin
  logic [5:0] run_len_r;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || !RESET_PIN_I) begin
      run_len_r <= 6'h00;
    end else if (run_len_r != 6'h3F) begin
      run_len_r <= run_len_r + 6'h01;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I || core_rst || PROGRAM_PULSE_MODE_I);
  AST_ALS_RATE: assert property ($rose(ADDRESS_LATCH_STROBE_O) && !dcyc_r && phase_r == 4'h1 |-> ##6 $rose(ADDRESS_LATCH_STROBE_O)) else $error("latch strobe rate broken");
  AST_ALS_SKIP: assert property ($rose(ADDRESS_LATCH_STROBE_O) && dcyc_r |-> ##2 !ADDRESS_LATCH_STROBE_O [*8]) else $error("data cycle latch strobe not skipped");
  AST_ADDR_AT_FALL: assert property ($fell(ADDRESS_LATCH_STROBE_O) && (dcyc_r || slot_ext_r) |-> P0_OE_O && $stable(P0_O)) else $error("low address not held at latch fall");
  AST_P0_DATA_WR: assert property (!DATA_WRITE_STROBE_N_O |-> P0_OE_O && P0_O == dwdata_r) else $error("write data missing on port 0");
  AST_P2_HIGH: assert property (ADDRESS_LATCH_STROBE_O && (dcyc_r || slot_ext_r) |-> P2_OE_O) else $error("high address not on port 2");
  AST_PFS_EXT: assert property ($rose(ADDRESS_LATCH_STROBE_O) && !dcyc_r && slot_ext_r |-> ##[1:3] $fell(PROGRAM_FETCH_STROBE_N_O)) else $error("external fetch strobe missing");
  AST_PFS_DATA: assert property (dcyc_r |-> PROGRAM_FETCH_STROBE_N_O) else $error("fetch strobe during data cycle");
  AST_PFS_INT: assert property ($rose(ADDRESS_LATCH_STROBE_O) && !slot_ext_r |-> PROGRAM_FETCH_STROBE_N_O [*5]) else $error("fetch strobe on internal fetch");
  AST_EXT_SEL: assert property (slot_end && (!INTERNAL_FETCH_SELECT_I || CODE_ADDR_I > ext_bus_pkg::INT_CODE_TOP) |=> slot_ext_r) else $error("external fetch not selected");
  AST_INT_SEL: assert property (slot_end && INTERNAL_FETCH_SELECT_I && CODE_ADDR_I <= ext_bus_pkg::INT_CODE_TOP |=> !slot_ext_r) else $error("internal fetch not selected");
  AST_RST_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I) $rose(CORE_RESET_O) |-> run_len_r == 6'(ext_bus_pkg::RST_HOLD_CYC)) else $error("reset qualified at wrong count");
  AST_IDLE_QUIET: assert property (CPU_HALT_O |=> !ADDRESS_LATCH_STROBE_O && PROGRAM_FETCH_STROBE_N_O) else $error("bus active while idle");
  AST_PD_HOLD: assert property (OSC_STOP_O |=> OSC_STOP_O && phase_r == 4'h0) else $error("power-down left without reset");
  AST_WR_CYCLE: assert property ($fell(DATA_WRITE_STROBE_N_O) |-> dcyc_r && dwe_r ##7 $rose(DATA_WRITE_STROBE_N_O)) else $error("write strobe width wrong");
  AST_PROGRAM_PULSE_PIN: assert property (@(posedge CLK_I) disable iff (!RST_N_I) PROGRAM_PULSE_MODE_I |=> !ADDRESS_LATCH_STROBE_OE_O && PROGRAM_PULSE_O == !$past(ADDRESS_LATCH_STROBE_I)) else $error("program pulse not taken from pin");
  COV_EXT_FETCH: cover property (CODE_VALID_O);
  COV_DATA_WRITE: cover property ($fell(DATA_WRITE_STROBE_N_O) ##7 XDATA_DONE_O);
  COV_DATA_READ: cover property ($fell(DATA_READ_STROBE_N_O));
  COV_IDLE_WAKE: cover property ($fell(CPU_HALT_O));
endmodule
`default_nettype wire

// file: verilog/ext_bus_pkg.sv
// constants and types shared by the external memory bus control block
package ext_bus_pkg;
  localparam int MC_OSC = 12;
  localparam int RST_HOLD_MC = 2;
  localparam int RST_HOLD_CYC = RST_HOLD_MC * MC_OSC;
  localparam logic [3:0] PH_LAST = 4'(MC_OSC - 1);
  localparam logic [3:0] SLOT_LEN = 4'(MC_OSC / 2);
  localparam logic [3:0] SLOT_LAST = 4'(MC_OSC / 2 - 1);
  localparam logic [3:0] SP_ALS_LAST = 4'h1;
  localparam logic [3:0] SP_ADDR_LAST = 4'h2;
  localparam logic [3:0] SP_STB_FIRST = 4'h3;
  localparam logic [3:0] SP_STB_LAST = 4'h4;
  localparam logic [3:0] SP_SAMPLE = 4'h5;
  localparam logic [3:0] DC_STB_FIRST = 4'h3;
  localparam logic [3:0] DC_STB_LAST = 4'h9;
  localparam logic [3:0] DC_SAMPLE = 4'hA;
  localparam logic [15:0] INT_CODE_TOP = 16'h0FFF;
  localparam logic [7:0] BUS_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PDOWN = 2'b10
  } mode_e;
endpackage

// file: verilog/bus_reset_qualify.sv
// qualifies the reset pin: high for a full hold count before reset asserts
`timescale 1ns/1ns
`default_nettype none
module bus_reset_qualify #(
  parameter int HOLD = ext_bus_pkg::RST_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic qual_o
);
  localparam int CW = $clog2(HOLD + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic qual_r;
  logic qual_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    qual_nxt = 1'b0;
    if (!pin_i) begin
      cnt_nxt = '0;
    end else begin
      if (cnt_r != CW'(HOLD)) begin
        cnt_nxt = cnt_r + CW'(1);
      end
      qual_nxt = (cnt_r >= CW'(HOLD - 1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      qual_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      qual_r <= qual_nxt;
    end
  end

  assign qual_o = qual_r;
endmodule
`default_nettype wire

// file: dv/ext_mem_model.sv
// external code/data memory with address latch, far side of the bus
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
  input wire logic clk_i,
  input wire logic als_i,
  input wire logic [7:0] ad_i,
  input wire logic ad_oe_i,
  input wire logic [7:0] ah_i,
  input wire logic fetch_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic [7:0] ad_o
);
  logic [7:0] xram [0:65535];
  logic [7:0] low_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [15:0] addr;

  function automatic logic [7:0] code_byte(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'hA5;
  endfunction

  // transparent latch: open while the strobe is high, holds after it falls
  always @(als_i or ad_i) begin
    if (als_i) begin
      low_r = ad_i;
    end
  end

  assign addr = {ah_i, low_r};

  // released bus shows the inverse of its last level, never a stale copy
  always_comb begin
    if (!fetch_n_i) begin
      ad_o = code_byte(addr);
    end else if (!rd_n_i) begin
      ad_o = xram[addr];
    end else if (ad_oe_i) begin
      ad_o = ad_i;
    end else begin
      ad_o = ~last_r;
    end
  end

  always @(posedge clk_i) begin
    if (!wr_n_i) begin
      xram[addr] <= ad_i;
    end
    // remember only driven levels, so a released bus keeps showing the inverse
    if (!fetch_n_i || !rd_n_i || ad_oe_i) begin
      last_r <= ad_o;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_ext_memory_bus_control.sv
// self-checking bench for the external memory bus control block
`timescale 1ns/1ns
`default_nettype none
module tb_ext_memory_bus_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rpin = 1'b0;
  logic fsel = 1'b1;
  logic pmode = 1'b0;
  logic ppin = 1'b1;
  logic [15:0] caddr = 16'h0000;
  logic [15:0] xaddr = 16'h0000;
  logic xreq = 1'b0;
  logic xwe = 1'b0;
  logic [7:0] xwd = 8'h00;
  logic idle = 1'b0;
  logic pdn = 1'b0;
  logic wake = 1'b0;
  logic core_rst, als, als_oe, ppulse, fs_n, fs_oe, p0oe, p2oe, wr_n, rd_n;
  logic cvalid, done, busy, halt, ostop;
  logic [7:0] p0o, p2o, cdata, rdata, p0_in;
  wire logic als_pin;
  wire logic fs_pin;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 56;
  int na, nf;
  logic [15:0] ta [0:4];
  logic [7:0] td [0:4];

  always #25 clk = ~clk;
  // in programming mode the bench plays the pulse source on the pin
  assign als_pin = als_oe ? als : ppin;
  // once released, the programmer ties the fetch strobe pin low
  assign fs_pin = fs_oe ? fs_n : 1'b0;

  ext_memory_bus_control ext_memory_bus_control_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .RESET_PIN_I(rpin), .INTERNAL_FETCH_SELECT_I(fsel),
    .PROGRAM_PULSE_MODE_I(pmode), .ADDRESS_LATCH_STROBE_I(als_pin), .CODE_ADDR_I(caddr),
    .XDATA_REQ_I(xreq), .XDATA_WE_I(xwe), .XDATA_ADDR_I(xaddr), .XDATA_WDATA_I(xwd),
    .IDLE_REQ_I(idle), .PDOWN_REQ_I(pdn), .WAKE_I(wake), .P0_I(p0_in),
    .CORE_RESET_O(core_rst), .ADDRESS_LATCH_STROBE_O(als),
    .ADDRESS_LATCH_STROBE_OE_O(als_oe), .PROGRAM_PULSE_O(ppulse),
    .PROGRAM_FETCH_STROBE_N_O(fs_n), .PROGRAM_FETCH_STROBE_OE_O(fs_oe),
    .P0_O(p0o), .P0_OE_O(p0oe), .P2_O(p2o), .P2_OE_O(p2oe),
    .DATA_WRITE_STROBE_N_O(wr_n), .DATA_READ_STROBE_N_O(rd_n),
    .CODE_DATA_O(cdata), .CODE_VALID_O(cvalid), .XDATA_RDATA_O(rdata),
    .XDATA_DONE_O(done), .XDATA_BUSY_O(busy), .CPU_HALT_O(halt), .OSC_STOP_O(ostop));

  ext_mem_model ext_mem_model_inst (
    .clk_i(clk), .als_i(als), .ad_i(p0o), .ad_oe_i(p0oe), .ah_i(p2o),
    .fetch_n_i(fs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .ad_o(p0_in));

  function automatic logic [7:0] code_exp(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // inputs change 2 ns after the edge, outputs are read there too
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // selectors for the status bit that the wait loop watches
  localparam int W_BUSY = 0, W_DONE = 1, W_HALT = 2, W_STOP = 3;

  function automatic logic pick(input int w);
    case (w)
      W_BUSY: return busy;
      W_DONE: return done;
      W_HALT: return halt;
      default: return ostop;
    endcase
  endfunction

  task automatic wait_bit(input int w, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(w) !== v && k < lim) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic run_count(input int n, output int ca, output int cf);
    logic pa, pf;
    pa = als;
    pf = fs_n;
    ca = 0;
    cf = 0;
    repeat (n) begin
      cyc(1);
      if (als && !pa) ca++;
      if (!fs_n && pf) cf++;
      if (cvalid === 1'b1) check("code byte", {8'h00, cdata}, {8'h00, code_exp(caddr)});
      pa = als;
      pf = fs_n;
    end
  endtask

  task automatic xfer(input logic we, input logic [15:0] a, input logic [7:0] d);
    wait_bit(W_BUSY, 1'b0, 40);
    xreq = 1'b1;
    xwe = we;
    xaddr = a;
    xwd = d;
    cyc(1);
    xreq = 1'b0;
    wait_bit(W_DONE, 1'b1, 40);
    check("data done", {15'h0000, done}, 16'h0001);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 50);
    mismatches++;
    report_and_stop();
  end

  initial begin
    cyc(6);
    rst_n = 1'b1;
    caddr = 16'h0FFF;
    cyc(24);
    run_count(120, na, nf);
    check("latch pulses", 16'(na), 16'd20);
    check("fetch strobes internal", 16'(nf), 16'd0);
    caddr = 16'h1000;
    cyc(24);
    run_count(120, na, nf);
    check("fetch strobes above top", 16'(nf), 16'd20);
    $display("test fetch select high done");
    fsel = 1'b0;
    caddr = 16'($random(seed)) & 16'h0FFF;
    cyc(24);
    run_count(120, na, nf);
    check("fetch strobes external", 16'(nf), 16'd20);
    fork
      run_count(120, na, nf);
      xfer(1'b1, 16'h1234, 8'h5C);
    join
    check("latch with data cycle", 16'(na), 16'd19);
    check("fetch with data cycle", 16'(nf), 16'd18);
    $display("test external fetch done");
    ta[0] = 16'hFFFF;
    ta[1] = 16'h00FF;
    for (int i = 0; i < 5; i++) begin
      if (i > 1) ta[i] = 16'($random(seed));
      td[i] = 8'($random(seed));
      xfer(1'b1, ta[i], td[i]);
    end
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, ta[i], 8'h00);
      cyc(1);
      check("read back", {8'h00, rdata}, {8'h00, td[i]});
    end
    $display("test data access done");
    idle = 1'b1;
    wait_bit(W_HALT, 1'b1, 13);
    idle = 1'b0;
    check("halt in idle", {15'h0000, halt}, 16'h0001);
    run_count(24, na, nf);
    check("latch in idle", 16'(na), 16'h0000);
    check("fetch in idle", 16'(nf), 16'h0000);
    wake = 1'b1;
    wait_bit(W_HALT, 1'b0, 13);
    wake = 1'b0;
    check("halt after wake", {15'h0000, halt}, 16'h0000);
    pdn = 1'b1;
    wait_bit(W_STOP, 1'b1, 13);
    pdn = 1'b0;
    check("oscillator stop", {15'h0000, ostop}, 16'h0001);
    run_count(24, na, nf);
    check("latch in power-down", 16'(na), 16'h0000);
    check("fetch in power-down", 16'(nf), 16'h0000);
    $display("test reduced power done");
    rpin = 1'b1;
    cyc(23);
    check("reset one short", {15'h0000, core_rst}, 16'h0000);
    cyc(1);
    check("reset qualified", {15'h0000, core_rst}, 16'h0001);
    rpin = 1'b0;
    cyc(2);
    check("reset released", {15'h0000, core_rst}, 16'h0000);
    check("power-down left", {15'h0000, ostop}, 16'h0000);
    $display("test reset pin done");
    pmode = 1'b1;
    cyc(2);
    check("latch pin released", {15'h0000, als_oe}, 16'h0000);
    check("fetch pin released", {15'h0000, fs_oe}, 16'h0000);
    check("fetch pin held low", {15'h0000, fs_pin}, 16'h0000);
    check("port 2 left to verifier", {15'h0000, p2oe}, 16'h0000);
    check("port 0 left to verifier", {15'h0000, p0oe}, 16'h0000);
    ppin = 1'b0;
    cyc(2);
    check("program pulse on", {15'h0000, ppulse}, 16'h0001);
    ppin = 1'b1;
    cyc(2);
    check("program pulse off", {15'h0000, ppulse}, 16'h0000);
    $display("test programming done");
    report_and_stop();
  end
endmodule
`default_nettype wire
